//--- dram_refresh_self_refresh.sv
`timescale 1ns/1ps
module dram_refresh_self_refresh #(
    parameter int ROW_W = 16
) (
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire dram_refresh_pkg::cmd_s     cmd,
    input  wire logic                       cke,
    input  wire logic                       auto_self_refresh_enable,
    input  wire logic                       self_refresh_temp_range,
    input  wire logic                       dll_off_bit,
    output logic                            self_refresh_active,
    output logic                            refresh_busy,
    output logic [ROW_W-1:0]                refresh_row,
    output logic                            auto_managed,
    output logic                            extended_rate,
    output logic                            mode_illegal,
    output logic                            dll_on,
    output logic                            dll_reset,
    output logic                            int_clk_en
);

    localparam int RFC_D = dram_refresh_pkg::REFRESH_CYCLES;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    dram_refresh_pkg::sr_state_e state_reg;
    logic [dram_refresh_pkg::TIMER_W-1:0] rfc_cnt_reg;
    logic [dram_refresh_pkg::TIMER_W-1:0] sr_tmr_reg;
    logic [ROW_W-1:0]                     row_reg;
    logic                                 cke_prev_reg;
    logic                                 auto_reg;
    logic                                 ext_reg;
    logic                                 illegal_reg;
    logic                                 dll_on_reg;
    logic                                 dll_reset_reg;
    logic                                 clk_en_reg;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic ref_pat;
    logic idle_pat;
    logic ext_ref;
    logic sr_enter;
    logic sr_exit;
    logic int_ref;
    logic ref_start;
    logic rfc_idle;

    assign ref_pat  = ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n & cmd.we_n;
    assign idle_pat = cmd.cs_n | (cmd.ras_n & cmd.cas_n & cmd.we_n);
    assign rfc_idle = (rfc_cnt_reg == dram_refresh_pkg::TIMER_ZERO);
    assign ext_ref  = (state_reg == dram_refresh_pkg::ST_IDLE) & cke_prev_reg & cke
                      & ref_pat & rfc_idle;
    assign sr_enter = (state_reg == dram_refresh_pkg::ST_IDLE) & cke_prev_reg & ~cke
                      & ref_pat;
    assign sr_exit  = (state_reg == dram_refresh_pkg::ST_SR) & cke & idle_pat;
    assign int_ref  = (state_reg == dram_refresh_pkg::ST_SR) & rfc_idle
                      & (sr_tmr_reg == dram_refresh_pkg::TIMER_ZERO);
    assign ref_start = ext_ref | int_ref;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= dram_refresh_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                dram_refresh_pkg::ST_IDLE: begin
                    if (sr_enter) begin
                        state_reg <= dram_refresh_pkg::ST_SR_ENTRY;
                    end
                end
                dram_refresh_pkg::ST_SR_ENTRY: begin
                    state_reg <= dram_refresh_pkg::ST_SR;
                end
                dram_refresh_pkg::ST_SR: begin
                    if (sr_exit) begin
                        state_reg <= dram_refresh_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= dram_refresh_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cke;
        end
    end

    // ------------------------------------------------------------------
    // refresh cycle and internal row counter
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rfc_cnt_reg <= dram_refresh_pkg::TIMER_ZERO;
        end else if (ref_start) begin
            rfc_cnt_reg <= dram_refresh_pkg::TIMER_W'(RFC_D);
        end else if (!rfc_idle) begin
            rfc_cnt_reg <= rfc_cnt_reg - dram_refresh_pkg::TIMER_ONE;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            row_reg <= '0;
        end else if (ref_start) begin
            row_reg <= row_reg + ROW_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // self-refresh timer: first refresh right after entry, then periodic
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sr_tmr_reg <= dram_refresh_pkg::TIMER_ZERO;
        end else if (state_reg == dram_refresh_pkg::ST_SR_ENTRY) begin
            sr_tmr_reg <= dram_refresh_pkg::TIMER_ZERO;
        end else if (int_ref) begin
            sr_tmr_reg <= ext_reg ?
                          dram_refresh_pkg::TIMER_W'(dram_refresh_pkg::SR_EXTENDED_CYC) :
                          dram_refresh_pkg::TIMER_W'(dram_refresh_pkg::SR_NORMAL_CYC);
        end else if (sr_tmr_reg != dram_refresh_pkg::TIMER_ZERO) begin
            sr_tmr_reg <= sr_tmr_reg - dram_refresh_pkg::TIMER_ONE;
        end
    end

    // ------------------------------------------------------------------
    // temperature mode
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            auto_reg    <= 1'b0;
            ext_reg     <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            auto_reg    <= auto_self_refresh_enable & ~self_refresh_temp_range;
            ext_reg     <= ~auto_self_refresh_enable & self_refresh_temp_range;
            illegal_reg <= auto_self_refresh_enable & self_refresh_temp_range;
        end
    end

    // ------------------------------------------------------------------
    // dll and internal clock
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dll_on_reg    <= 1'b0;
            dll_reset_reg <= 1'b0;
        end else begin
            dll_reset_reg <= 1'b0;
            if (sr_enter) begin
                dll_on_reg <= 1'b0;
            end else if (sr_exit) begin
                dll_on_reg    <= ~dll_off_bit;
                dll_reset_reg <= ~dll_off_bit;
            end else if (state_reg == dram_refresh_pkg::ST_IDLE) begin
                dll_on_reg <= ~dll_off_bit;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk_en_reg <= 1'b1;
        end else if (sr_enter) begin
            clk_en_reg <= 1'b0;
        end else if (sr_exit) begin
            clk_en_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign self_refresh_active = (state_reg != dram_refresh_pkg::ST_IDLE);
    assign refresh_busy        = ~rfc_idle;
    assign refresh_row         = row_reg;
    assign auto_managed        = auto_reg;
    assign extended_rate       = ext_reg;
    assign mode_illegal        = illegal_reg;
    assign dll_on              = dll_on_reg;
    assign dll_reset           = dll_reset_reg;
    assign int_clk_en          = clk_en_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_auto_mode;
        @(posedge sys_clk) disable iff (!resetn)
        (auto_self_refresh_enable && !self_refresh_temp_range) |=> auto_managed && !extended_rate;
    endproperty
    a_auto_mode: assert property (p_auto_mode) else $error("auto mode not taken");

    property p_ext_rate;
        @(posedge sys_clk) disable iff (!resetn)
        (int_ref && extended_rate) |=>
            sr_tmr_reg == dram_refresh_pkg::TIMER_W'(dram_refresh_pkg::SR_EXTENDED_CYC);
    endproperty
    a_ext_rate: assert property (p_ext_rate) else $error("wrong self-refresh rate");

    property p_ref_decode;
        @(posedge sys_clk) disable iff (!resetn)
        ext_ref |=> refresh_busy && refresh_row == $past(refresh_row) + ROW_W'(1);
    endproperty
    a_ref_decode: assert property (p_ref_decode) else $error("refresh not started");

    property p_ref_done;
        @(posedge sys_clk) disable iff (!resetn)
        ref_start |-> ##RFC_D refresh_busy ##1 !refresh_busy;
    endproperty
    a_ref_done: assert property (p_ref_done) else $error("banks not idle in time");

    property p_sr_entry;
        @(posedge sys_clk) disable iff (!resetn)
        sr_enter |=> self_refresh_active ##1 (state_reg == dram_refresh_pkg::ST_SR);
    endproperty
    a_sr_entry: assert property (p_sr_entry) else $error("self-refresh not entered");

    property p_sr_hold;
        @(posedge sys_clk) disable iff (!resetn)
        (state_reg == dram_refresh_pkg::ST_SR && !cke) |=> self_refresh_active && !int_clk_en;
    endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("left self-refresh with cke low");

    property p_dll;
        @(posedge sys_clk) disable iff (!resetn)
        (sr_exit && !dll_off_bit) |=> dll_on && dll_reset ##1 !dll_reset;
    endproperty
    a_dll: assert property (p_dll) else $error("dll not restored on exit");

    property p_sr_internal;
        @(posedge sys_clk) disable iff (!resetn)
        (sr_enter && !refresh_busy) |=> !int_clk_en ##1 (!cke)[*1] |->
            ##[0:RFC_D] refresh_busy;
    endproperty
    a_sr_internal: assert property (p_sr_internal) else $error("no internal refresh");

    c_refresh:  cover property (@(posedge sys_clk) disable iff (!resetn) ext_ref);
    c_sr_cycle: cover property (@(posedge sys_clk) disable iff (!resetn) sr_enter ##[2:50] sr_exit);
    c_sr_int:   cover property (@(posedge sys_clk) disable iff (!resetn) int_ref);

endmodule : dram_refresh_self_refresh

//--- dram_refresh_pkg.sv
package dram_refresh_pkg;

    // ------------------------------------------------------------------
    // command pins sampled on the rising clock edge
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_s;

    // ------------------------------------------------------------------
    // refresh state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_SR_ENTRY = 2'b01,
        ST_SR       = 2'b10
    } sr_state_e;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 20;
    localparam int REFRESH_CYCLE_NS = 350;
    localparam int SR_NORMAL_NS     = 7800;
    localparam int SR_EXTENDED_NS   = 3900;
    localparam int REFRESH_CYCLES   = (REFRESH_CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SR_NORMAL_CYC    = (SR_NORMAL_NS * CLK_MHZ) / 1000;
    localparam int SR_EXTENDED_CYC  = (SR_EXTENDED_NS * CLK_MHZ) / 1000;
    localparam int TIMER_W          = 12;

    localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
    localparam logic [TIMER_W-1:0] TIMER_ONE  = 12'h001;

endpackage : dram_refresh_pkg

//--- dram_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// memory controller model: drives command pins and clock enable
// ----------------------------------------------------------------------
module dram_ctrl_model (
    input  wire logic                   sys_clk,
    output dram_refresh_pkg::cmd_s      cmd,
    output logic                        cke
);
    localparam dram_refresh_pkg::cmd_s DESEL = 4'hf;
    localparam dram_refresh_pkg::cmd_s REF   = 4'h1;
    localparam int                     POSTPONE_MAX = 8;

    int                                owed;
    logic                              in_sr;

    initial begin
        cmd   = DESEL;
        cke   = 1'b1;
        owed  = 0;
        in_sr = 1'b0;
    end

    // refresh debt: one per average interval, frozen in self-refresh
    initial begin
        forever begin
            repeat (dram_refresh_pkg::SR_NORMAL_CYC) @(posedge sys_clk);
            if (!in_sr) owed++;
        end
    end

    // one command edge, then a deselect on the following edge
    task automatic send(input dram_refresh_pkg::cmd_s c, input logic k);
        @(posedge sys_clk);
        #1 cmd = c;
        cke = k;
        @(posedge sys_clk);
        #1 cmd = DESEL;
    endtask : send

    // banks always idle here, next command only after the refresh cycle
    task automatic refresh();
        send(REF, 1'b1);
        if (owed > -POSTPONE_MAX) owed--;
        repeat (dram_refresh_pkg::REFRESH_CYCLES) @(posedge sys_clk);
    endtask : refresh

    // entry with exactly one deselect after it, clock enable held low
    task automatic sr_enter();
        send(REF, 1'b0);
        in_sr = 1'b1;
    endtask : sr_enter

    // exit: clock enable high with a deselect on the bus
    task automatic sr_exit();
        @(posedge sys_clk);
        #1 cke = 1'b1;
        in_sr = 1'b0;
    endtask : sr_exit

    // only deselects during the exit delay, then one extra refresh
    task automatic sr_tail();
        repeat (dram_refresh_pkg::REFRESH_CYCLES + 2) @(posedge sys_clk);
        refresh();
    endtask : sr_tail
endmodule : dram_ctrl_model

//--- dram_refresh_self_refresh_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// testbench
// ----------------------------------------------------------------------
module dram_refresh_self_refresh_bench;
    logic                   sys_clk;
    logic                   resetn;
    dram_refresh_pkg::cmd_s cmd;
    logic                   cke;
    logic                   a6;
    logic                   a7;
    logic                   dll_off;
    logic                   sr_act;
    logic                   busy;
    logic [15:0]            row;
    logic                   auto_m;
    logic                   ext;
    logic                   ill;
    logic                   dll_on;
    logic                   dll_rst;
    logic                   clk_en;
    logic [15:0]            r0;
    int                     failures;
    int                     checks_done;
    // {a6, a7, dll_off} beside {auto, extended, illegal, dll_on}
    localparam logic [6:0]  ROWS [4] = '{7'h01, 7'h34, 7'h49, 7'h72};
    localparam dram_refresh_pkg::cmd_s REF = 4'h1;

    dram_refresh_self_refresh dram_refresh_self_refresh_inst (
        .sys_clk(sys_clk), .resetn(resetn), .cmd(cmd), .cke(cke),
        .auto_self_refresh_enable(a6), .self_refresh_temp_range(a7),
        .dll_off_bit(dll_off), .self_refresh_active(sr_act), .refresh_busy(busy),
        .refresh_row(row), .auto_managed(auto_m), .extended_rate(ext),
        .mode_illegal(ill), .dll_on(dll_on), .dll_reset(dll_rst), .int_clk_en(clk_en)
    );

    dram_ctrl_model dram_ctrl_model_inst (.sys_clk(sys_clk), .cmd(cmd), .cke(cke));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t ns: %s", $time, msg);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        #(5000 * 50);
        failures++;
        final_report();
    end

    // ------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------
    initial begin
        failures = 0;
        checks_done = 0;
        resetn = 1'b0;
        {a6, a7, dll_off} = 3'h0;
        repeat (16) @(posedge sys_clk);
        #1;
        check({sr_act, busy, dll_on, dll_rst, clk_en}, 16'h0001, "reset outputs");
        check(row, 16'h0000, "reset row");
        resetn = 1'b1;
        foreach (ROWS[i]) begin
            @(posedge sys_clk);
            #1 {a6, a7, dll_off} = ROWS[i][6:4];
            tick(2);
            check({auto_m, ext, ill, dll_on}, 16'(ROWS[i][3:0]), "mode");
        end
        @(posedge sys_clk);
        #1 {a6, a7, dll_off} = 3'h0;
        tick(2);
        r0 = row;
        dram_ctrl_model_inst.send(REF, 1'b1);
        tick(1);
        check(busy, 16'h0001, "refresh start");
        check(row, r0 + 16'h0001, "row step");
        dram_ctrl_model_inst.send(REF, 1'b1);
        tick(dram_refresh_pkg::REFRESH_CYCLES - 4);
        check(busy, 16'h0001, "refresh length");
        tick(1);
        check(busy, 16'h0000, "refresh end");
        check(row, r0 + 16'h0001, "refresh while busy");
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            #1 {a6, a7, dll_off} = {1'b0, k[0], k[0]};
            tick(1);
            r0 = row;
            dram_ctrl_model_inst.sr_enter();
            tick(1);
            check({sr_act, clk_en, dll_on}, 16'h0004, "entry outputs");
            dram_ctrl_model_inst.send(REF, 1'b0);
            tick(81);
            check(row, r0 + 16'(k + 1), "internal refresh count");
            dram_ctrl_model_inst.sr_exit();
            tick(1);
            check({sr_act, clk_en}, 16'h0001, "exit outputs");
            check({dll_on, dll_rst}, {14'h0, ~k[0], ~k[0]}, "dll on exit");
            tick(1);
            check(dll_rst, 16'h0000, "dll reset pulse");
            dram_ctrl_model_inst.sr_tail();
        end
        dram_ctrl_model_inst.sr_enter();
        tick(2);
        @(posedge sys_clk);
        #1 resetn = 1'b0;
        tick(1);
        check({sr_act, busy, clk_en}, 16'h0001, "reset in self-refresh");
        check(row, 16'h0000, "row after reset");
        @(posedge sys_clk);
        #1 resetn = 1'b1;
        tick(1);
        check({sr_act, busy, clk_en}, 16'h0001, "cke low after reset");
        dram_ctrl_model_inst.sr_exit();
        dram_ctrl_model_inst.refresh();
        tick(1);
        check(row, 16'h0001, "first refresh after reset");
        final_report();
    end
endmodule : dram_refresh_self_refresh_bench
